// ===== core/tw_bit_engine.v
`timescale 1ns/100ps
`include "tw_consts.vh"
module tw_bit_engine
#(
  parameter QTR_CYC = `TW_QTR_CYC
)
(
  input  wire       pclk,      // Clock
  input  wire       presetn,   // Async reset
  input  wire       cmd_start, // Issue start condition
  input  wire       cmd_byte,  // Issue one byte plus ack bit
  input  wire       cmd_stop,  // Issue stop condition
  input  wire [7:0] tx_byte,   // Byte to send, FF to receive
  input  wire       ack_out,   // Ack bit value we drive
  output reg        done,      // Command finished pulse
  output wire [7:0] rx_byte,   // Sampled byte
  output wire       ack_in,    // Sampled ack bit, 1 is nack
  output reg        scl_o,     // Clock pin out
  output reg        scl_oe,    // Clock pin pull low
  input  wire       sda_i,     // Data pin in
  output reg        sda_o,     // Data pin out
  output reg        sda_oe     // Data pin pull low
);
  localparam E_IDLE  = 2'd0;
  localparam E_START = 2'd1;
  localparam E_BIT   = 2'd2;
  localparam E_STOP  = 2'd3;

  reg [1:0]  st_ff;
  reg [1:0]  ph_ff;
  reg [3:0]  bit_ff;
  reg [8:0]  txsh_ff;
  reg [8:0]  rxsh_ff;
  reg [15:0] cnt_ff;
  reg        sda_m_ff;
  reg        sda_s_ff;
  wire       tick;

  assign tick    = (st_ff != E_IDLE) && (cnt_ff == QTR_CYC[15:0] - 16'h0001);
  assign rx_byte = rxsh_ff[8:1];
  assign ack_in  = rxsh_ff[0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end
    else
    begin
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
    end
  end

  // No clock stretching: the slave cannot hold the clock low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff   <= E_IDLE;
      ph_ff   <= 2'd0;
      bit_ff  <= 4'h0;
      txsh_ff <= 9'h1FF;
      rxsh_ff <= 9'h000;
      cnt_ff  <= 16'h0000;
      done    <= 1'b0;
      scl_o   <= 1'b0;
      sda_o   <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (st_ff == E_IDLE || tick)
        cnt_ff <= 16'h0000;
      else
        cnt_ff <= cnt_ff + 16'h0001;
      case (st_ff)
        E_IDLE:
        begin
          ph_ff   <= 2'd0;
          bit_ff  <= 4'h0;
          txsh_ff <= {tx_byte, ack_out};
          if (cmd_start)
            st_ff <= E_START;
          else if (cmd_byte)
            st_ff <= E_BIT;
          else if (cmd_stop)
            st_ff <= E_STOP;
        end
        E_START:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'd1;
            if (ph_ff == 2'd0)
            begin
              sda_oe <= 1'b0;
              scl_oe <= 1'b0;
            end
            else if (ph_ff == 2'd1)
              sda_oe <= 1'b1;
            else
            begin
              scl_oe <= 1'b1;
              done   <= 1'b1;
              st_ff  <= E_IDLE;
            end
          end
        E_BIT:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'd1;
            if (ph_ff == 2'd0)
              sda_oe <= ~txsh_ff[8];
            else if (ph_ff == 2'd1)
              scl_oe <= 1'b0;
            else if (ph_ff == 2'd2)
              rxsh_ff <= {rxsh_ff[7:0], sda_s_ff};
            else
            begin
              scl_oe  <= 1'b1;
              txsh_ff <= {txsh_ff[7:0], 1'b1};
              bit_ff  <= bit_ff + 4'h1;
              if (bit_ff == 4'h8)
              begin
                done  <= 1'b1;
                st_ff <= E_IDLE;
              end
            end
          end
        default:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'd1;
            if (ph_ff == 2'd0)
              sda_oe <= 1'b1;
            else if (ph_ff == 2'd1)
              scl_oe <= 1'b0;
            else
            begin
              sda_oe <= 1'b0;
              done   <= 1'b1;
              st_ff  <= E_IDLE;
            end
          end
      endcase
    end
  end
endmodule

// ===== core/tw_event_ctrl.v
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "tw_consts.vh"
module tw_event_ctrl
#(
  parameter QTR_CYC = `TW_QTR_CYC
)
(
  input  wire        pclk,    // Clock, 200 MHz
  input  wire        presetn, // Async reset, active low
  input  wire        psel,    // APB select
  input  wire        penable, // APB access phase
  input  wire        pwrite,  // APB write
  input  wire [11:0] paddr,   // APB byte address
  input  wire [31:0] pwdata,  // APB write data
  output reg  [31:0] prdata,  // APB read data
  output reg         pready,  // APB ready
  output reg         pslverr, // APB error, unmapped address
  output reg         irq,     // Interrupt request, level
  output wire        scl_o,   // Clock pin out
  output wire        scl_oe,  // Clock pin pull low
  input  wire        sda_i,   // Data pin in
  output wire        sda_o,   // Data pin out
  output wire        sda_oe   // Data pin pull low
);
  localparam M_IDLE  = 3'd0;
  localparam M_START = 3'd1;
  localparam M_BOUND = 3'd2;
  localparam M_XFER  = 3'd3;
  localparam M_SUSP  = 3'd4;
  localparam M_STOP  = 3'd5;

  reg [2:0]             state_ff;
  reg [2:0]             nxt_state;
  reg [1:0]             shortcuts_ff;
  reg [`TW_EV_NUM-1:0]  inten_ff;
  reg [`TW_EV_NUM-1:0]  ev_ff;
  reg [`TW_EV_NUM-1:0]  ev_set;
  reg [6:0]             address_ff;
  reg [7:0]             txd_ff;
  reg [7:0]             rxd_ff;
  reg                   is_rd_ff;
  reg                   first_ff;
  reg                   susp_pend_ff;
  reg                   stop_pend_ff;
  reg                   cmd_start_ff;
  reg                   cmd_byte_ff;
  reg                   cmd_stop_ff;
  reg [7:0]             tx_byte_ff;
  reg                   ack_out_ff;
  reg                   nxt_cmd_start;
  reg                   nxt_cmd_byte;
  reg                   nxt_cmd_stop;
  reg [7:0]             nxt_tx_byte;
  reg                   nxt_ack_out;
  reg                   susp_set;
  reg                   stop_set;
  reg                   pend_clr;
  reg                   susp_clr;
  wire                  eng_done;
  wire [7:0]            eng_rx;
  wire                  eng_ack_in;
  wire                  wr_acc;
  wire                  rd_setup;
  wire                  task_start_rx;
  wire                  task_start_tx;
  wire                  task_stop;
  wire                  task_suspend;
  wire                  task_resume;
  wire [`TW_EV_NUM-1:0] ev_clr;

  function reg_mapped;
    input [11:0] a;
    begin
      case (a)
        `TW_OFS_START_RX, `TW_OFS_START_TX, `TW_OFS_STOP, `TW_OFS_SUSPEND,
        `TW_OFS_RESUME, `TW_OFS_EV_STOPPED, `TW_OFS_EV_RXREADY,
        `TW_OFS_EV_TXSENT, `TW_OFS_EV_ERROR, `TW_OFS_EV_BOUNDARY,
        `TW_OFS_EV_SUSPENDED, `TW_OFS_SHORTCUTS, `TW_OFS_INTEN_SET,
        `TW_OFS_INTEN_CLR, `TW_OFS_RXD, `TW_OFS_TXD, `TW_OFS_ADDRESS:
          reg_mapped = 1'b1;
        default:
          reg_mapped = 1'b0;
      endcase
    end
  endfunction

  function task_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      task_hit = wr_acc && (a == ofs) && pwdata[0];
    end
  endfunction

  // Zero wait states: pready rises in the first access cycle
  assign wr_acc   = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;

  assign task_start_rx = task_hit(paddr, `TW_OFS_START_RX);
  assign task_start_tx = task_hit(paddr, `TW_OFS_START_TX);
  assign task_stop     = task_hit(paddr, `TW_OFS_STOP);
  assign task_suspend  = task_hit(paddr, `TW_OFS_SUSPEND);
  assign task_resume   = task_hit(paddr, `TW_OFS_RESUME);

  assign ev_clr[`TW_EV_STOPPED]   = task_hit(paddr, `TW_OFS_EV_STOPPED);
  assign ev_clr[`TW_EV_RXREADY]   = task_hit(paddr, `TW_OFS_EV_RXREADY);
  assign ev_clr[`TW_EV_TXSENT]    = task_hit(paddr, `TW_OFS_EV_TXSENT);
  assign ev_clr[`TW_EV_ERROR]     = task_hit(paddr, `TW_OFS_EV_ERROR);
  assign ev_clr[`TW_EV_BOUNDARY]  = task_hit(paddr, `TW_OFS_EV_BOUNDARY);
  assign ev_clr[`TW_EV_SUSPENDED] = task_hit(paddr, `TW_OFS_EV_SUSPENDED);

  // Transfer sequencer
  always @*
  begin
    nxt_state     = state_ff;
    ev_set        = {`TW_EV_NUM{1'b0}};
    nxt_cmd_start = 1'b0;
    nxt_cmd_byte  = 1'b0;
    nxt_cmd_stop  = 1'b0;
    nxt_tx_byte   = tx_byte_ff;
    nxt_ack_out   = ack_out_ff;
    susp_set      = task_suspend;
    stop_set      = task_stop;
    pend_clr      = 1'b0;
    susp_clr      = 1'b0;
    case (state_ff)
      M_IDLE:
        if (task_start_rx || task_start_tx)
        begin
          nxt_cmd_start = 1'b1;
          nxt_state     = M_START;
        end
      M_START:
        if (eng_done)
          nxt_state = M_BOUND;
      M_BOUND:
        if (!is_rd_ff && !first_ff && stop_pend_ff)
        begin
          nxt_cmd_stop = 1'b1;
          nxt_state    = M_STOP;
        end
        else
        begin
          // [RULE1] event ahead of each byte
          ev_set[`TW_EV_BOUNDARY] = 1'b1;
          // [RULE5] shortcuts fire on the boundary
          if (shortcuts_ff[`TW_SC_PAUSE])
            susp_set = 1'b1;
          if (shortcuts_ff[`TW_SC_HALT])
            stop_set = 1'b1;
          nxt_cmd_byte = 1'b1;
          if (first_ff)
            nxt_tx_byte = {address_ff, is_rd_ff};
          else if (is_rd_ff)
            nxt_tx_byte = 8'hFF;
          else
            nxt_tx_byte = txd_ff;
          // Ack slot left to the slave, except a read byte that is not the last
          nxt_ack_out = first_ff || !is_rd_ff || stop_pend_ff ||
                        task_stop || shortcuts_ff[`TW_SC_HALT];
          nxt_state   = M_XFER;
        end
      M_XFER:
        if (eng_done)
        begin
          if (first_ff || !is_rd_ff)
          begin
            if (!first_ff)
              ev_set[`TW_EV_TXSENT] = 1'b1;
            if (eng_ack_in)
            begin
              ev_set[`TW_EV_ERROR] = 1'b1;
              nxt_cmd_stop         = 1'b1;
              nxt_state            = M_STOP;
            end
            else
              nxt_state = M_BOUND;
          end
          else
          begin
            ev_set[`TW_EV_RXREADY] = 1'b1;
            if (stop_pend_ff)
            begin
              nxt_cmd_stop = 1'b1;
              nxt_state    = M_STOP;
            end
            // [RULE2] suspend lands right after the ack bit
            // [RULE3] only when a suspend is pending
            else if (susp_pend_ff || task_suspend)
            begin
              ev_set[`TW_EV_SUSPENDED] = 1'b1;
              susp_clr                 = 1'b1;
              nxt_state                = M_SUSP;
            end
            else
              nxt_state = M_BOUND;
          end
        end
      M_SUSP:
        // [RULE4] engine idles with clock held low
        if (task_stop)
        begin
          nxt_cmd_stop = 1'b1;
          nxt_state    = M_STOP;
        end
        // [RULE8] resume continues with the next byte
        else if (task_resume)
          nxt_state = M_BOUND;
      M_STOP:
        if (eng_done)
        begin
          ev_set[`TW_EV_STOPPED] = 1'b1;
          pend_clr               = 1'b1;
          nxt_state              = M_IDLE;
        end
      default:
        nxt_state = M_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff     <= M_IDLE;
      is_rd_ff     <= 1'b0;
      first_ff     <= 1'b0;
      susp_pend_ff <= 1'b0;
      stop_pend_ff <= 1'b0;
      cmd_start_ff <= 1'b0;
      cmd_byte_ff  <= 1'b0;
      cmd_stop_ff  <= 1'b0;
      tx_byte_ff   <= 8'hFF;
      ack_out_ff   <= 1'b0;
      rxd_ff       <= 8'h00;
    end
    else
    begin
      state_ff     <= nxt_state;
      cmd_start_ff <= nxt_cmd_start;
      cmd_byte_ff  <= nxt_cmd_byte;
      cmd_stop_ff  <= nxt_cmd_stop;
      tx_byte_ff   <= nxt_tx_byte;
      ack_out_ff   <= nxt_ack_out;
      if (nxt_cmd_start)
      begin
        is_rd_ff <= task_start_rx;
        first_ff <= 1'b1;
      end
      else if (state_ff == M_XFER && eng_done)
        first_ff <= 1'b0;
      if (state_ff == M_XFER && eng_done && is_rd_ff && !first_ff)
        rxd_ff <= eng_rx;
      // Pending requests only matter while a transfer is live
      if (pend_clr || state_ff == M_IDLE)
      begin
        susp_pend_ff <= 1'b0;
        stop_pend_ff <= 1'b0;
      end
      else
      begin
        if (susp_clr)
          susp_pend_ff <= 1'b0;
        else if (susp_set)
          susp_pend_ff <= 1'b1;
        if (stop_set)
          stop_pend_ff <= 1'b1;
      end
    end
  end

  // Register file
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shortcuts_ff <= `TW_RST_SHORTCUTS;
      inten_ff     <= `TW_RST_INTEN;
      ev_ff        <= {`TW_EV_NUM{1'b0}};
      address_ff   <= 7'h00;
      txd_ff       <= 8'h00;
      irq          <= 1'b0;
    end
    else
    begin
      // Set beats a clear landing in the same cycle
      ev_ff <= (ev_ff & ~ev_clr) | ev_set;
      // [RULE10] enabled flag drives the interrupt
      irq   <= |(ev_ff & inten_ff);
      if (wr_acc)
      begin
        case (paddr)
          `TW_OFS_SHORTCUTS:
            shortcuts_ff <= pwdata[1:0];
          // [RULE6] write 1 enables, 0 leaves it
          `TW_OFS_INTEN_SET:
            inten_ff <= inten_ff | pwdata[`TW_EV_NUM-1:0];
          // [RULE9] write 1 disables
          `TW_OFS_INTEN_CLR:
            inten_ff <= inten_ff & ~pwdata[`TW_EV_NUM-1:0];
          `TW_OFS_TXD:
            txd_ff <= pwdata[7:0];
          `TW_OFS_ADDRESS:
            address_ff <= pwdata[6:0];
          default:
            txd_ff <= txd_ff;
        endcase
      end
    end
  end

  // Read data is registered at the end of the setup cycle and is valid in the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !reg_mapped(paddr);
      if (rd_setup && !pwrite)
      begin
        case (paddr)
          `TW_OFS_EV_STOPPED:   prdata <= {31'h0, ev_ff[`TW_EV_STOPPED]};
          `TW_OFS_EV_RXREADY:   prdata <= {31'h0, ev_ff[`TW_EV_RXREADY]};
          `TW_OFS_EV_TXSENT:    prdata <= {31'h0, ev_ff[`TW_EV_TXSENT]};
          `TW_OFS_EV_ERROR:     prdata <= {31'h0, ev_ff[`TW_EV_ERROR]};
          `TW_OFS_EV_BOUNDARY:  prdata <= {31'h0, ev_ff[`TW_EV_BOUNDARY]};
          `TW_OFS_EV_SUSPENDED: prdata <= {31'h0, ev_ff[`TW_EV_SUSPENDED]};
          `TW_OFS_SHORTCUTS:    prdata <= {30'h0, shortcuts_ff};
          // [RULE7] six enable fields read back
          `TW_OFS_INTEN_SET:    prdata <= {26'h0, inten_ff};
          `TW_OFS_INTEN_CLR:    prdata <= {26'h0, inten_ff};
          `TW_OFS_RXD:          prdata <= {24'h0, rxd_ff};
          `TW_OFS_TXD:          prdata <= {24'h0, txd_ff};
          `TW_OFS_ADDRESS:      prdata <= {25'h0, address_ff};
          default:              prdata <= 32'h00000000;
        endcase
      end
    end
  end

  tw_bit_engine
  #(
    .QTR_CYC (QTR_CYC)
  )
  u_engine
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .cmd_start (cmd_start_ff),
    .cmd_byte  (cmd_byte_ff),
    .cmd_stop  (cmd_stop_ff),
    .tx_byte   (tx_byte_ff),
    .ack_out   (ack_out_ff),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .ack_in    (eng_ack_in),
    .scl_o     (scl_o),
    .scl_oe    (scl_oe),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe)
  );
endmodule

// ===== shared/tw_consts.vh
// How it works
// [RULE1] Boundary event fires before every byte
// [RULE2] Read: suspended event right after ACK
// [RULE3] No suspended event without prior suspend
// [RULE4] Suspended state holds clock low, bus paused
// [RULE5] Shortcut bit0 suspends, bit1 stops, per boundary
// [RULE6] Enable-set writes 1 enable; read shows enables
// [RULE7] Six enables: stopped, rx, tx, error, boundary, suspended
// [RULE8] Resume task releases a suspended transfer
// [RULE9] Enable-clear writes 1 disable; same read-back
// [RULE10] Interrupt while enabled flag set; 0 ignored
`ifndef TW_CONSTS_VH
`define TW_CONSTS_VH

`define TW_OFS_START_RX     12'h000
`define TW_OFS_START_TX     12'h008
`define TW_OFS_STOP         12'h014
`define TW_OFS_SUSPEND      12'h01C
`define TW_OFS_RESUME       12'h020
`define TW_OFS_EV_STOPPED   12'h104
`define TW_OFS_EV_RXREADY   12'h108
`define TW_OFS_EV_TXSENT    12'h11C
`define TW_OFS_EV_ERROR     12'h124
`define TW_OFS_EV_BOUNDARY  12'h138
`define TW_OFS_EV_SUSPENDED 12'h148
`define TW_OFS_SHORTCUTS    12'h200
`define TW_OFS_INTEN_SET    12'h304
`define TW_OFS_INTEN_CLR    12'h308
`define TW_OFS_RXD          12'h518
`define TW_OFS_TXD          12'h51C
`define TW_OFS_ADDRESS      12'h588

// Event / enable bit positions
`define TW_EV_STOPPED   0
`define TW_EV_RXREADY   1
`define TW_EV_TXSENT    2
`define TW_EV_ERROR     3
`define TW_EV_BOUNDARY  4
`define TW_EV_SUSPENDED 5
`define TW_EV_NUM       6

// Shortcut bit positions
`define TW_SC_PAUSE 0
`define TW_SC_HALT  1

`define TW_RST_SHORTCUTS 2'h0
`define TW_RST_INTEN     6'h00

// Bit timing: a bit is four quarter periods
`define TW_PCLK_KHZ 200000
`define TW_SCL_KHZ  100
`define TW_QTR_CYC  ((`TW_PCLK_KHZ) / (4 * `TW_SCL_KHZ))

`endif

// ===== sim/tw_event_ctrl_assertions.sv
`timescale 1ns/100ps
module tw_event_ctrl_chk
#(
  parameter QTR_CYC = 500
)
(
  input wire        pclk,    // Clock
  input wire        presetn, // Reset, active low
  input wire        psel,    // Select
  input wire        penable, // Access phase
  input wire        pwrite,  // Write
  input wire [11:0] paddr,   // Address
  input wire [31:0] pwdata,  // Write data
  input wire [31:0] prdata,  // Read data
  input wire        pready,  // Ready
  input wire        pslverr, // Error
  input wire        irq,     // Interrupt
  input wire        scl_o,   // Clock out
  input wire        scl_oe,  // Clock pull
  input wire        sda_i,   // Data in
  input wire        sda_o,   // Data out
  input wire        sda_oe   // Data pull
);
  reg  [5:0] en_sh;
  reg  [1:0] sc_sh;
  reg        held;
  wire       acc = psel && penable && pready;
  wire       wr  = acc && pwrite && pwdata[0];

  // Shadow of enables, shortcuts and the suspended state seen by software
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en_sh <= 6'h00;
      sc_sh <= 2'h0;
      held  <= 1'b0;
    end
    else
    begin
      if (acc && pwrite && paddr == 12'h304)
        en_sh <= en_sh | pwdata[5:0];
      if (acc && pwrite && paddr == 12'h308)
        en_sh <= en_sh & ~pwdata[5:0];
      if (acc && pwrite && paddr == 12'h200)
        sc_sh <= pwdata[1:0];
      if (acc && !pwrite && paddr == 12'h148 && prdata[0])
        held <= 1'b1;
      else if (wr && (paddr == 12'h020 || paddr == 12'h014))
        held <= 1'b0;
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("ready outside access");
  err_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response wrong");
  en_read_a: assert property (
    pready && !pwrite && (paddr == 12'h304 || paddr == 12'h308) |-> prdata == {26'h0, en_sh})
    else $error("enable read-back wrong");
  sc_read_a: assert property (pready && !pwrite && paddr == 12'h200 |-> prdata == {30'h0, sc_sh})
    else $error("shortcut read-back wrong");
  irq_mask_a: assert property (en_sh == 6'h00 |=> !irq)
    else $error("irq with all enables off");
  held_low_a: assert property (held |-> scl_oe)
    else $error("clock released while suspended");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  reset_rel_a: assert property ($rose(presetn) |-> !scl_oe && !sda_oe && !irq)
    else $error("lines not released at reset");
endmodule

bind tw_event_ctrl tw_event_ctrl_chk #(.QTR_CYC(QTR_CYC)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// ===== sim/tw_event_ctrl_test.sv
`timescale 1ns/100ps
module tw_event_ctrl_test;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe, s_oe;
  wire        scl_w = !scl_oe;
  wire        sda_w = !(sda_oe || s_oe);
  integer     fails = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  reg  [31:0] rd_d;
  reg         rd_e;

  tw_event_ctrl #(.QTR_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  tw_slave_model slv (.scl(scl_w), .sda(sda_w), .pull_oe(s_oe));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task report_and_stop;
  begin
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Hang guard, well above the expected run
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  task check(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  // One APB transfer; an idle edge follows so strobes never change twice at once
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rc(input [11:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    check(rd_d, e);
  end
  endtask

  task wait_ev(input [11:0] a);
  begin
    apb(1'b0, a, 32'h0);
    while (rd_d[0] !== 1'b1)
      apb(1'b0, a, 32'h0);
  end
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(12'h200, 32'h0);
    rc(12'h304, 32'h0);
    rc(12'h308, 32'h0);
    rc(12'h7F0, 32'h0);
    check({31'h0, rd_e}, 32'h1);
    wr(12'h304, 32'h3F);
    rc(12'h304, 32'h3F);
    wr(12'h304, 32'h0);
    rc(12'h304, 32'h3F);
    wr(12'h308, 32'h1F);
    rc(12'h308, 32'h20);
    rc(12'h304, 32'h20);
    wr(12'h200, 32'h3);
    rc(12'h200, 32'h3);
    wr(12'h200, 32'h0);
    wr(12'h588, 32'h55);
    // Plain read: a byte arrives and nothing pauses
    wr(12'h000, 32'h1);
    wait_ev(12'h108);
    rc(12'h138, 32'h1);
    rc(12'h148, 32'h0);
    rc(12'h518, 32'hA5);
    wr(12'h014, 32'h1);
    wait_ev(12'h104);
    rc(12'h148, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(12'h104, 32'h1);
    wr(12'h108, 32'h1);
    wr(12'h138, 32'h1);
    // Suspend requested once the read is live; an idle block drops it
    wr(12'h000, 32'h1);
    wr(12'h01C, 32'h1);
    wait_ev(12'h148);
    check({31'h0, irq}, 32'h1);
    rc(12'h108, 32'h1);
    repeat (40) @(posedge pclk);
    check({31'h0, scl_w}, 32'h0);
    wr(12'h308, 32'h20);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(12'h304, 32'h20);
    wr(12'h148, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(12'h138, 32'h1);
    wr(12'h200, 32'h1);
    wr(12'h020, 32'h1);
    wait_ev(12'h148);
    rc(12'h138, 32'h1);
    wr(12'h148, 32'h1);
    wr(12'h200, 32'h2);
    wr(12'h020, 32'h1);
    wait_ev(12'h104);
    rc(12'h148, 32'h0);
    check({30'h0, scl_w, sda_w}, 32'h3);
    // Write transfer: suspend stays pending, sent bytes never pause
    wr(12'h104, 32'h1);
    wr(12'h138, 32'h1);
    wr(12'h200, 32'h0);
    wr(12'h51C, 32'h3C);
    wr(12'h008, 32'h1);
    wr(12'h01C, 32'h1);
    wait_ev(12'h11C);
    rc(12'h138, 32'h1);
    rc(12'h148, 32'h0);
    wr(12'h014, 32'h1);
    wait_ev(12'h104);
    rc(12'h124, 32'h0);
    rc(12'h148, 32'h0);
    check({30'h0, scl_w, sda_w}, 32'h3);
    report_and_stop;
  end
endmodule

// ===== sim/tw_slave_model.sv
`timescale 1ns/100ps
module tw_slave_model
#(
  parameter [7:0] RD_BYTE = 8'hA5
)
(
  input  wire scl,    // Clock line level
  input  wire sda,    // Data line level
  output reg  pull_oe // High pulls data low
);
  integer cnt;
  reg     rd;
  reg     adr;
  reg     quiet;
  initial
  begin
    pull_oe = 1'b0;
    cnt = 0;
    rd = 1'b0;
    adr = 1'b0;
    quiet = 1'b0;
  end
  // Start condition restarts the byte count
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      adr = 1'b1;
      quiet = 1'b0;
    end
  always @(posedge scl)
  begin
    if (adr && cnt == 7)
      rd = sda;
    // A nack from the master ends our driving
    if (rd && !adr && cnt == 8 && sda)
      quiet = 1'b1;
    cnt = cnt + 1;
    if (cnt == 9)
    begin
      cnt = 0;
      adr = 1'b0;
    end
  end
  // Data changes only while the clock is low
  always @(negedge scl)
    if (cnt == 8)
      pull_oe <= adr || !rd;
    else
      pull_oe <= rd && !adr && !quiet && !RD_BYTE[7 - cnt];
endmodule
